// *** adcpc_pkg.sv ***
package adcpc_pkg;

  // three-level pin codes from the window comparator pair {above_upper, above_lower}
  localparam logic [1:0] LVL_LOW  = 2'h0;
  localparam logic [1:0] LVL_MID  = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h3;

  typedef struct packed {
    logic hi;
    logic mid;
    logic lo;
  } adcpc_lvl_t;

  localparam adcpc_lvl_t LVL_RESET = '{hi: 1'b1, mid: 1'b0, lo: 1'b0};

  // calibration trigger timing, in clk cycles (counted while ce is high)
  localparam int             TUNE_CNT_W           = 12;
  localparam logic [11:0]    TUNE_LOW_MIN_CYCLES  = 12'h010;
  localparam logic [11:0]    TUNE_HIGH_MIN_CYCLES = 12'h010;
  localparam logic [11:0]    TUNE_RUN_CYCLES      = 12'h400;
  localparam logic [11:0]    TUNE_CNT_MAX         = 12'hfff;

  typedef enum logic [3:0] {
    TS_IDLE = 4'b0001,
    TS_LOW  = 4'b0010,
    TS_HIGH = 4'b0100,
    TS_RUN  = 4'b1000
  } adcpc_tune_st_t;

  // register map, byte addresses
  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h04;
  localparam logic [7:0]  ADDR_REALIGN   = 8'h08;
  localparam int          CTRL_RANGE_BIT = 0;
  localparam logic        CTRL_RANGE_RST = 1'b1;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef struct packed {
    logic [25:0] zero;
    logic        diff_realign;
    logic        dual_edge;
    logic        ext_mode;
    logic        range_high;
    logic        shutdown;
    logic        tune_active;
  } adcpc_status_t;

endpackage

// *** adcpc_tri_dec.sv ***
`timescale 1ns/1ps
module adcpc_tri_dec (
  // clock, reset, enable
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  // comparator pair code
  input  wire logic [1:0]         code,
  // decoded level
  output adcpc_pkg::adcpc_lvl_t   lvl
);

  wire logic is_low  = (code == adcpc_pkg::LVL_LOW);
  wire logic is_mid  = (code == adcpc_pkg::LVL_MID);
  wire logic is_high = (code == adcpc_pkg::LVL_HIGH);
  wire logic legal   = is_low | is_mid | is_high;

  // the fourth code cannot come from a sane comparator pair; keep the last level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl <= adcpc_pkg::LVL_RESET;
    end else if (ce && legal) begin
      lvl <= '{hi: is_high, mid: is_mid, lo: is_low};
    end
  end

endmodule

// *** adcpc_top.sv ***
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - select high/mid: single-ended realign pulse
// - select low: realign pin is positive half
// - select low: range pin is negative half
// - shutdown high powers down whole converter
// - low then high trigger pattern starts calibration
// - tune active high only while calibrating
// - single-ended, pin mode: range pin picks range
// - differential realign: range defaults to high
// - extended mode: dual-edge pin is chip select
// - pin mode, mid level: dual-edge sampling
// - sample on falling edge of clock leg
// - range from pin or adjust register
// - enable pin low selects extended control
module adcpc_top (
  // clock, reset, enable
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire logic                          ce,
  // control pins
  input  wire logic [1:0]                    realign_style_select,
  input  wire logic                          clock_realign_pulse_pos,
  input  wire logic                          input_range_select,
  input  wire logic                          extended_ctrl_enable,
  input  wire logic                          full_shutdown_in,
  input  wire logic                          tune_trigger_in,
  input  wire logic [1:0]                    dual_edge_select,
  input  wire logic                          sample_clk_pos,
  // axi4-lite write
  input  wire logic [adcpc_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // axi4-lite read
  input  wire logic [adcpc_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // converter controls
  output logic                               output_data_clock_realign,
  output logic                               power_down_out,
  output logic                               tune_active_out,
  output logic                               range_high,
  output logic                               serial_select_n,
  output logic                               dual_edge_mode,
  output logic                               sample_strobe
);

  // reset release through two flops; assertion is still asynchronous
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // three-level pins
  adcpc_pkg::adcpc_lvl_t style_lvl;
  adcpc_pkg::adcpc_lvl_t des_lvl;

  adcpc_tri_dec u_style_dec (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .code  (realign_style_select),
    .lvl   (style_lvl)
  );

  adcpc_tri_dec u_des_dec (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .code  (dual_edge_select),
    .lvl   (des_lvl)
  );

  // mode decode
  wire logic diff_mode = style_lvl.lo;
  wire logic ext_mode  = ~extended_ctrl_enable;
  wire logic clock_realign_pulse_neg = input_range_select;
  wire logic realign_level = diff_mode ?
             (clock_realign_pulse_pos & ~clock_realign_pulse_neg) :
             clock_realign_pulse_pos;

  // software range control
  logic ctrl_range;

  // extended mode wins, since the adjust register is then authoritative
  wire logic next_range_high = ext_mode  ? ctrl_range :
                               diff_mode ? 1'b1 :
                               input_range_select;
  wire logic next_dual_edge  = ~ext_mode & des_lvl.mid;
  // deselected in pin mode so the serial port ignores stray edges
  wire logic next_select_n   = ext_mode ? ~des_lvl.lo : 1'b1;

  // edge detection on the realign and sample-clock inputs
  logic realign_prev;
  logic sample_prev;
  logic [15:0] realign_count;

  wire logic realign_rise = realign_level & ~realign_prev;
  wire logic sample_fall  = sample_prev & ~sample_clk_pos;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      realign_prev              <= 1'b0;
      sample_prev               <= 1'b0;
      output_data_clock_realign <= 1'b0;
      sample_strobe             <= 1'b0;
      power_down_out            <= 1'b0;
      range_high                <= adcpc_pkg::CTRL_RANGE_RST;
      dual_edge_mode            <= 1'b0;
      serial_select_n           <= 1'b1;
      realign_count             <= 16'h0000;
    end else if (ce) begin
      realign_prev              <= realign_level;
      sample_prev               <= sample_clk_pos;
      output_data_clock_realign <= realign_rise & ~full_shutdown_in;
      sample_strobe             <= sample_fall & ~full_shutdown_in;
      power_down_out            <= full_shutdown_in;
      range_high                <= next_range_high;
      dual_edge_mode            <= next_dual_edge;
      serial_select_n           <= next_select_n;
      if (realign_rise && !full_shutdown_in) begin
        realign_count <= realign_count + 16'h0001;
      end
    end
  end

  // calibration trigger detector and run timer
  adcpc_pkg::adcpc_tune_st_t tune_st;
  adcpc_pkg::adcpc_tune_st_t next_tune_st;
  logic [adcpc_pkg::TUNE_CNT_W-1:0] tune_cnt;
  logic [adcpc_pkg::TUNE_CNT_W-1:0] next_tune_cnt;

  wire logic low_met  = (tune_cnt >= adcpc_pkg::TUNE_LOW_MIN_CYCLES);
  wire logic high_met = (tune_cnt >= adcpc_pkg::TUNE_HIGH_MIN_CYCLES);
  wire logic run_done = (tune_cnt == adcpc_pkg::TUNE_RUN_CYCLES - 12'h001);
  wire logic cnt_sat  = (tune_cnt == adcpc_pkg::TUNE_CNT_MAX);

  always_comb begin
    next_tune_st  = tune_st;
    next_tune_cnt = tune_cnt;
    unique case (tune_st)
      adcpc_pkg::TS_IDLE: begin
        if (!tune_trigger_in) begin
          next_tune_st  = adcpc_pkg::TS_LOW;
          next_tune_cnt = 12'h001;
        end
      end
      adcpc_pkg::TS_LOW: begin
        if (tune_trigger_in) begin
          // a short low phase is discarded, the whole pattern starts over
          next_tune_st  = low_met ? adcpc_pkg::TS_HIGH : adcpc_pkg::TS_IDLE;
          next_tune_cnt = low_met ? 12'h001 : 12'h000;
        end else if (!cnt_sat) begin
          next_tune_cnt = tune_cnt + 12'h001;
        end
      end
      adcpc_pkg::TS_HIGH: begin
        if (!tune_trigger_in) begin
          next_tune_st  = adcpc_pkg::TS_LOW;
          next_tune_cnt = 12'h001;
        end else if (high_met) begin
          next_tune_st  = adcpc_pkg::TS_RUN;
          next_tune_cnt = 12'h000;
        end else begin
          next_tune_cnt = tune_cnt + 12'h001;
        end
      end
      adcpc_pkg::TS_RUN: begin
        next_tune_cnt = tune_cnt + 12'h001;
        if (run_done) begin
          next_tune_st  = adcpc_pkg::TS_IDLE;
          next_tune_cnt = 12'h000;
        end
      end
      default: begin
        next_tune_st  = adcpc_pkg::TS_IDLE;
        next_tune_cnt = 12'h000;
      end
    endcase
    // no calibration while powered down
    if (full_shutdown_in) begin
      next_tune_st  = adcpc_pkg::TS_IDLE;
      next_tune_cnt = 12'h000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tune_st         <= adcpc_pkg::TS_IDLE;
      tune_cnt        <= 12'h000;
      tune_active_out <= 1'b0;
    end else if (ce) begin
      tune_st         <= next_tune_st;
      tune_cnt        <= next_tune_cnt;
      tune_active_out <= (next_tune_st == adcpc_pkg::TS_RUN);
    end
  end

  // axi4-lite slave: address and data held until both are in, then one response
  logic [adcpc_pkg::ADDR_W-1:0] waddr_q;
  logic [31:0]                  wdata_q;
  logic [3:0]                   wstrb_q;

  wire logic aw_hs   = s_axi_awvalid & s_axi_awready;
  wire logic w_hs    = s_axi_wvalid & s_axi_wready;
  wire logic b_hs    = s_axi_bvalid & s_axi_bready;
  wire logic ar_hs   = s_axi_arvalid & s_axi_arready;
  wire logic r_hs    = s_axi_rvalid & s_axi_rready;
  wire logic wr_go   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire logic wr_ctrl = (waddr_q == adcpc_pkg::ADDR_CTRL);

  adcpc_pkg::adcpc_status_t status;
  assign status = '{zero: 26'h0, diff_realign: diff_mode, dual_edge: dual_edge_mode,
                    ext_mode: ext_mode, range_high: range_high,
                    shutdown: power_down_out, tune_active: tune_active_out};

  wire logic rd_ctrl    = (s_axi_araddr == adcpc_pkg::ADDR_CTRL);
  wire logic rd_status  = (s_axi_araddr == adcpc_pkg::ADDR_STATUS);
  wire logic rd_realign = (s_axi_araddr == adcpc_pkg::ADDR_REALIGN);
  wire logic rd_hit     = rd_ctrl | rd_status | rd_realign;
  wire logic [31:0] rd_mux = rd_ctrl    ? {31'h0, ctrl_range} :
                             rd_status  ? status :
                             rd_realign ? {16'h0, realign_count} : 32'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= adcpc_pkg::RESP_OKAY;
      waddr_q       <= '0;
      wdata_q       <= 32'h0;
      wstrb_q       <= 4'h0;
      ctrl_range    <= adcpc_pkg::CTRL_RANGE_RST;
    end else if (ce) begin
      if (aw_hs) begin
        s_axi_awready <= 1'b0;
        waddr_q       <= s_axi_awaddr;
      end
      if (w_hs) begin
        s_axi_wready <= 1'b0;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ctrl ? adcpc_pkg::RESP_OKAY : adcpc_pkg::RESP_SLVERR;
        if (wr_ctrl && wstrb_q[0]) begin
          ctrl_range <= wdata_q[adcpc_pkg::CTRL_RANGE_BIT];
        end
      end
      if (b_hs) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= adcpc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (ar_hs) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_hit ? adcpc_pkg::RESP_OKAY : adcpc_pkg::RESP_SLVERR;
      end else if (r_hs) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b0;
      end
    end
  end

  // checks; a stalled clock enable voids any attempt in flight
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n || !ce);

  a_shutdown_follows: assert property (
    full_shutdown_in |=> power_down_out && !tune_active_out)
    else $error("shutdown did not reach power down");

  a_realign_single: assert property (
    (!diff_mode && !realign_prev && clock_realign_pulse_pos && !full_shutdown_in)
      |=> output_data_clock_realign ##1 !output_data_clock_realign || $past(realign_rise))
    else $error("single-ended realign pulse missed");

  a_realign_diff: assert property (
    (diff_mode && clock_realign_pulse_neg) |=> !output_data_clock_realign)
    else $error("differential realign fired with negative half high");

  a_range_diff: assert property (
    (diff_mode && !ext_mode) |=> range_high)
    else $error("differential mode range not high");

  a_range_source: assert property (
    1'b1 |=> range_high == ($past(ext_mode) ? $past(ctrl_range) :
                            $past(diff_mode) | $past(input_range_select)))
    else $error("range taken from wrong source");

  a_serial_select: assert property (
    (ext_mode && des_lvl.lo) |=> !serial_select_n)
    else $error("chip select not passed in extended mode");

  a_dual_edge_mid: assert property (
    1'b1 |=> dual_edge_mode == ($past(des_lvl.mid) && !$past(ext_mode)))
    else $error("dual-edge mode wrong for pin level");

  a_sample_fall: assert property (
    ($fell(sample_clk_pos) && !full_shutdown_in) |=> sample_strobe)
    else $error("falling sample edge not strobed");

  a_tune_low_gate: assert property (
    (tune_st == adcpc_pkg::TS_LOW && tune_trigger_in && !full_shutdown_in)
      |=> (tune_st == adcpc_pkg::TS_HIGH) == $past(low_met))
    else $error("low phase gate wrong");

  a_tune_start_high: assert property (
    $rose(tune_active_out) |-> $past(tune_trigger_in, 2) && $past(tune_trigger_in, 3))
    else $error("calibration started without high phase");

  a_tune_run_span: assert property (
    (tune_st == adcpc_pkg::TS_RUN) |-> tune_cnt < adcpc_pkg::TUNE_RUN_CYCLES)
    else $error("calibration ran too long");

  a_axi_b_hold: assert property (
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

  c_tune_run: cover property ($rose(tune_active_out));
  c_realign: cover property (output_data_clock_realign && diff_mode);
  c_dual_edge: cover property ($rose(dual_edge_mode));
  c_write: cover property (b_hs && wr_ctrl);

endmodule

// *** adcpc_board.sv ***
`timescale 1ns/1ps
module adcpc_board (
  // clock
  input  wire logic        clk,
  // commands from the bench
  input  wire logic        go,
  input  wire logic [11:0] low_len,
  input  wire logic [11:0] high_len,
  input  wire logic        run,
  // pins into the converter, and busy back to the bench
  output logic             tune_trigger_in,
  output logic             sample_clk_pos,
  output logic             busy
);
  // the sample clock leg stands still while not running
  initial begin
    sample_clk_pos = 1'b0;
    forever begin
      @(posedge clk);
      if (run) begin
        sample_clk_pos <= ~sample_clk_pos;
      end
    end
  end

  initial begin
    tune_trigger_in = 1'b1;
    busy            = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy            <= 1'b1;
        tune_trigger_in <= 1'b0;
        repeat (low_len) @(posedge clk);
        tune_trigger_in <= 1'b1;
        repeat (high_len) @(posedge clk);
        busy            <= 1'b0;
      end
    end
  end
endmodule

// *** test_adcpc_top.sv ***
`timescale 1ns/1ps
module test_adcpc_top;
  logic        clk, resetn, pos, rng, pin_mode, shd, go, run;
  logic [1:0]  style, des, bresp, rresp, rs;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [11:0] low_len, high_len;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        realign, pdo, tact, rhigh, ssn, dem, strobe, trig, sclk, busy;
  int          errors = 0, checked = 0, cycles = 0, n_al = 0, n_st = 0, n_tu = 0, b = 0;

  adcpc_top u_adcpc_top (
    .clk(clk), .resetn(resetn), .ce(1'b1), .realign_style_select(style),
    .clock_realign_pulse_pos(pos), .input_range_select(rng), .extended_ctrl_enable(pin_mode),
    .full_shutdown_in(shd), .tune_trigger_in(trig), .dual_edge_select(des),
    .sample_clk_pos(sclk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .output_data_clock_realign(realign), .power_down_out(pdo), .tune_active_out(tact),
    .range_high(rhigh), .serial_select_n(ssn), .dual_edge_mode(dem), .sample_strobe(strobe)
  );
  adcpc_board u_adcpc_board (
    .clk(clk), .go(go), .low_len(low_len), .high_len(high_len), .run(run),
    .tune_trigger_in(trig), .sample_clk_pos(sclk), .busy(busy)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // one-cycle outputs are counted here so no pulse slips between samples
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (realign === 1'b1) n_al <= n_al + 1;
    if (strobe === 1'b1) n_st <= n_st + 1;
    if (tact === 1'b1) n_tu <= n_tu + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // three-level pins need the decoder's extra cycle before the edge
  task automatic pulse();
    wait_n(4);
    pos <= 1'b1;
    wait_n(3);
    pos <= 1'b0;
    wait_n(4);
  endtask

  task automatic t_reset();
    check("range_high", rhigh, 1);
    check("serial_select_n", ssn, 1);
    rd_reg(adcpc_pkg::ADDR_STATUS, rd, rs);
    check("status", rd, 32'h00000004);
    rd_reg(adcpc_pkg::ADDR_REALIGN, rd, rs);
    check("realign count", rd, 0);
    rd_reg(8'h0c, rd, rs);
    check("unmapped resp", rs, adcpc_pkg::RESP_SLVERR);
    check("unmapped data", rd, 0);
    wr(adcpc_pkg::ADDR_STATUS, 32'hffffffff, rs);
    check("read-only resp", rs, adcpc_pkg::RESP_SLVERR);
  endtask

  task automatic t_realign();
    for (int i = 0; i < 2; i++) begin
      style <= i ? adcpc_pkg::LVL_MID : adcpc_pkg::LVL_HIGH;
      b = n_al;
      pulse();
      check("single-ended realign", n_al - b, 1);
    end
    style <= adcpc_pkg::LVL_LOW;
    rng   <= 1'b0;
    b = n_al;
    pulse();
    check("differential realign", n_al - b, 1);
    rng <= 1'b1;
    pulse();
    check("negative half high", n_al - b, 1);
    rd_reg(adcpc_pkg::ADDR_REALIGN, rd, rs);
    check("realign count", rd, 3);
    style <= adcpc_pkg::LVL_HIGH;
    shd   <= 1'b1;
    pulse();
    check("realign in shutdown", n_al - b, 1);
    check("power down", pdo, 1);
    shd <= 1'b0;
    wait_n(3);
    check("power up", pdo, 0);
  endtask

  task automatic t_range();
    rng <= 1'b0;
    wait_n(4);
    check("range pin low", rhigh, 0);
    rng <= 1'b1;
    wait_n(4);
    check("range pin high", rhigh, 1);
    style <= adcpc_pkg::LVL_LOW;
    rng   <= 1'b0;
    wait_n(4);
    check("differential range", rhigh, 1);
    style    <= adcpc_pkg::LVL_HIGH;
    pin_mode <= 1'b0;
    wr(adcpc_pkg::ADDR_CTRL, 32'h0, rs);
    check("ctrl write resp", rs, adcpc_pkg::RESP_OKAY);
    wait_n(4);
    check("register range", rhigh, 0);
    check("chip select idle", ssn, 1);
    des <= adcpc_pkg::LVL_LOW;
    wait_n(4);
    check("chip select", ssn, 0);
    rd_reg(adcpc_pkg::ADDR_STATUS, rd, rs);
    check("ext mode", rd[3], 1);
    wr(adcpc_pkg::ADDR_CTRL, 32'h1, rs);
    pin_mode <= 1'b1;
    des      <= adcpc_pkg::LVL_HIGH;
    wait_n(4);
    check("pin mode select", ssn, 1);
  endtask

  task automatic t_dual();
    logic [1:0] c[3];
    logic       e[3];
    // low is left out: in pin mode an unused pin must sit high;
    // the spare comparator code must keep the last level
    c = '{adcpc_pkg::LVL_MID, 2'h2, adcpc_pkg::LVL_HIGH};
    e = '{1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 3; i++) begin
      des <= c[i];
      wait_n(4);
      check("dual edge", dem, e[i]);
    end
  endtask

  task automatic t_strobe();
    b = n_st;
    run <= 1'b1;
    wait_n(16);
    run <= 1'b0;
    wait_n(4);
    check("sample strobes", n_st - b, 8);
  endtask

  task automatic go_tune(input logic [11:0] l, input logic [11:0] h);
    low_len  <= l;
    high_len <= h;
    go       <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy) @(posedge clk);
  endtask

  task automatic t_tune();
    b = n_tu;
    go_tune(adcpc_pkg::TUNE_LOW_MIN_CYCLES - 12'h1, 12'h014);
    wait_n(5);
    check("short low phase", n_tu - b, 0);
    go_tune(adcpc_pkg::TUNE_LOW_MIN_CYCLES, adcpc_pkg::TUNE_HIGH_MIN_CYCLES + 12'h1);
    for (int i = 0; i < 20 && tact !== 1'b1; i++) @(posedge clk);
    check("tune started", tact, 1);
    for (int i = 0; i < 1100 && tact !== 1'b0; i++) @(posedge clk);
    check("tune length", n_tu - b, adcpc_pkg::TUNE_RUN_CYCLES);
  endtask

  initial begin
    {resetn, pos, shd, go, run, awvalid, wvalid, bready, arvalid, rready} = '0;
    {rng, pin_mode} = 2'h3;
    style    = adcpc_pkg::LVL_HIGH;
    des      = adcpc_pkg::LVL_HIGH;
    {awaddr, araddr, wdata, low_len, high_len} = '0;
    wstrb    = 4'hf;
    wait_n(10);
    resetn <= 1'b1;
    wait_n(3);
    t_reset();
    t_realign();
    t_range();
    t_dual();
    t_strobe();
    t_tune();
    print_verdict();
  end
endmodule
